// File: rtl/fpm_params.svh
// constants for the port a data lane map of the first fast controller
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH
`define FPM_CELL_BYTES 6'd53
`define FPM_CELL_LAST 6'd52
`define FPM_IDLE_HDR 8'h00
`define FPM_IDLE_HDR_LAST 6'd3
`define FPM_IDLE_HEC 8'h52
`define FPM_HEC_IDX 6'd4
`define FPM_IDLE_FILL 8'h6A
`define FPM_ID_TX_SECTION 1'b0
`define FPM_ID_RX_SECTION 1'b1
`define FPM_ID_SECTION_BIT 5
`define FPM_NIB_TX_LO 4
`define FPM_NIB_RX_LO 4
`define FPM_SER_BIT 7
`define FPM_PIN_18 7
`define FPM_PIN_17 7
`define FPM_PIN_13 3
`define FPM_PIN_22 3
`endif

// File: rtl/fpm_pkg.sv
// types shared by the port a data lane map
package fpm_pkg;
	typedef enum logic [2:0] {
		fpm_mode_off,
		fpm_mode_utopia,
		fpm_mode_nibble,
		fpm_mode_serial
	} fpm_mode_type;
	typedef enum logic [1:0] {
		fpm_tx_idle,
		fpm_tx_data,
		fpm_tx_fill
	} fpm_tx_state_type;
endpackage

// File: rtl/fpm_in_sync.sv
// three stage synchroniser for pin inputs, change taken once two agree
`timescale 1ns/10ps
module fpm_in_sync
	import fpm_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// per bit: accept the new value only when stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				next_level[i] = level[i];
				if (stage2[i] == stage3[i])
					next_level[i] = stage3[i];
			end
		end
	endgenerate

	// stage1 is read by stage2 only, to contain metastability
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end
		else
		begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end
endmodule // fpm_in_sync

// File: rtl/fpm_id_capture.sv
// serial dma requester identifier output and error capture
`timescale 1ns/10ps
`include "fpm_params.svh"
module fpm_id_capture
	import fpm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic dma_active,
	input wire logic [4:0] dma_sub_block,
	input wire logic dma_rx_section,
	input wire logic dma_error,
	output logic [5:0] dma_requester_id,
	output logic [5:0] dma_error_id,
	output logic dma_error_seen
);
	logic [5:0] next_id;
	logic [5:0] next_err_id;
	logic next_err_seen;

	// identifier is section bit over the sub-block code
	always_comb
	begin
		next_id = dma_requester_id;
		next_err_id = dma_error_id;
		next_err_seen = dma_error_seen;
		if (dma_active)
		begin
			next_id[4:0] = dma_sub_block;
			next_id[`FPM_ID_SECTION_BIT] = dma_rx_section ?
				`FPM_ID_RX_SECTION : `FPM_ID_TX_SECTION;
		end
		// capture what is on the identifier during the failing transfer
		if (dma_error)
		begin
			next_err_id = dma_active ? next_id : dma_requester_id;
			next_err_seen = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dma_requester_id <= '0;
			dma_error_id <= '0;
			dma_error_seen <= 1'b0;
		end
		else
		begin
			dma_requester_id <= next_id;
			dma_error_id <= next_err_id;
			dma_error_seen <= next_err_seen;
		end
	end
endmodule // fpm_id_capture

// File: rtl/fpm_lane_map.sv
// port a lane map for the first fast communications controller
`timescale 1ns/10ps
`include "fpm_params.svh"
module fpm_lane_map
	import fpm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire fpm_mode_type mode,
	input wire logic tx_cell_start,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_byte_ready,
	input wire logic tx_phy_enable,
	input wire logic rx_phy_enable,
	input wire logic [3:0] tx_nibble,
	input wire logic tx_serial_bit,
	input wire logic dma_active,
	input wire logic [4:0] dma_sub_block,
	input wire logic dma_rx_section,
	input wire logic dma_error,
	output logic [7:0] pa_tx_out,
	output logic [7:0] pa_tx_oe,
	input wire logic [7:0] pa_rx_in,
	output logic [5:0] pa_id_out,
	output logic [5:0] pa_id_oe,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic rx_cell_start,
	output logic [3:0] rx_nibble,
	output logic rx_serial_bit,
	output logic [5:0] dma_error_id,
	output logic dma_error_seen
);
	fpm_tx_state_type tx_state;
	fpm_tx_state_type next_tx_state;
	logic [5:0] tx_count;
	logic [5:0] next_tx_count;
	logic [7:0] tx_lanes;
	logic [7:0] next_tx_lanes;
	logic [7:0] rx_lvl;
	logic rx_en_lvl;
	logic rx_en_d;
	logic rx_en_dd;
	logic rx_take;
	logic [5:0] rx_count;
	logic [5:0] next_rx_count;
	logic [7:0] next_rx_byte;
	logic next_rx_valid;
	logic next_rx_start;
	logic [3:0] next_rx_nibble;
	logic next_rx_serial;
	logic [5:0] id_value;
	logic [7:0] idle_byte;

	// pin inputs cross into the clock domain before use
	fpm_in_sync #(.WIDTH(8)) u_rx_sync
	(
		.clk(clk),
		.rst(rst),
		.pin(pa_rx_in),
		.level(rx_lvl)
	);

	fpm_in_sync #(.WIDTH(1)) u_en_sync
	(
		.clk(clk),
		.rst(rst),
		.pin(rx_phy_enable),
		.level(rx_en_lvl)
	);

	fpm_id_capture u_id
	(
		.clk(clk),
		.rst(rst),
		.dma_active(dma_active),
		.dma_sub_block(dma_sub_block),
		.dma_rx_section(dma_rx_section),
		.dma_error(dma_error),
		.dma_requester_id(id_value),
		.dma_error_id(dma_error_id),
		.dma_error_seen(dma_error_seen)
	);

	// idle cell: four zero header bytes, fixed hec, then fill payload
	// limitation: the idle pattern is fixed, not programmable
	always_comb
	begin
		if (tx_count <= `FPM_IDLE_HDR_LAST)
			idle_byte = `FPM_IDLE_HDR;
		else if (tx_count == `FPM_HEC_IDX)
			idle_byte = `FPM_IDLE_HEC;
		else
			idle_byte = `FPM_IDLE_FILL;
	end

	// user is ready only inside a data cell, and only when the phy pulls
	// ready is combinational so a stalled phy stops the user at once
	always_comb
	begin
		tx_byte_ready = 1'b0;
		if (mode == fpm_mode_utopia && tx_phy_enable)
			tx_byte_ready = (tx_state == fpm_tx_data) ||
				(tx_state == fpm_tx_idle && tx_cell_start);
	end

	// utopia transmit cell sequencer; a cell once begun completes unless mode leaves utopia, which drops it back to idle
	always_comb
	begin
		next_tx_state = tx_state;
		next_tx_count = tx_count;
		next_tx_lanes = tx_lanes;
		case (tx_state)
			fpm_tx_idle:
			begin
				if (mode == fpm_mode_utopia && tx_phy_enable)
				begin
					next_tx_count = 6'd1;
					if (tx_cell_start && tx_byte_valid)
					begin
						next_tx_state = fpm_tx_data;
						next_tx_lanes = tx_byte;
					end
					else
					begin
						next_tx_state = fpm_tx_fill;
						next_tx_lanes = `FPM_IDLE_HDR;
					end
				end
			end
			fpm_tx_data:
			begin
				if (tx_phy_enable)
				begin
					// an underrun mid-cell repeats the fill byte
					next_tx_lanes = tx_byte_valid ? tx_byte : `FPM_IDLE_FILL;
					next_tx_count = tx_count + 6'd1;
					if (tx_count == `FPM_CELL_LAST)
						next_tx_state = fpm_tx_idle;
				end
			end
			fpm_tx_fill:
			begin
				if (tx_phy_enable)
				begin
					next_tx_lanes = idle_byte;
					next_tx_count = tx_count + 6'd1;
					if (tx_count == `FPM_CELL_LAST)
						next_tx_state = fpm_tx_idle;
				end
			end
			// the unused state code recovers to idle
			default:
			begin
				next_tx_state = fpm_tx_idle;
				next_tx_count = '0;
			end
		endcase
		if (mode == fpm_mode_nibble)
			next_tx_lanes = {tx_nibble[0], tx_nibble[1], tx_nibble[2],
				tx_nibble[3], 4'h0};
		else if (mode == fpm_mode_serial)
			next_tx_lanes = {tx_serial_bit, 7'h00};
		else if (mode != fpm_mode_utopia)
			next_tx_lanes = 8'h00;
		if (mode != fpm_mode_utopia)
		begin
			next_tx_state = fpm_tx_idle;
			next_tx_count = '0;
		end
	end

	// transmit state, byte count and lane register; lanes come from
	// flip-flops so the pins never show combinational glitches
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_state <= fpm_tx_idle;
			tx_count <= '0;
			tx_lanes <= '0;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_count <= next_tx_count;
			tx_lanes <= next_tx_lanes;
		end
	end

	// drive only the lanes the selected mode owns
	always_comb
	begin
		pa_tx_out = tx_lanes;
		case (mode)
			fpm_mode_utopia: pa_tx_oe = 8'hFF;
			fpm_mode_nibble: pa_tx_oe = 8'hF0;
			fpm_mode_serial: pa_tx_oe = 8'h80;
			// mode off leaves every lane to the port's other users
			default: pa_tx_oe = 8'h00;
		endcase
	end

	// requester id shares rx pins; it drives only when they are not inputs
	// limitation: no lane mode can show the identifier on the pins
	always_comb
	begin
		pa_id_out = id_value;
		if (mode == fpm_mode_off)
			pa_id_oe = 6'h3F;
		else
			pa_id_oe = 6'h00;
	end

	// one byte per enable pulse: the lane filter needs every level held
	// for two clocks, so counting enabled cycles would repeat a byte
	assign rx_take = rx_en_d && !rx_en_dd;

	// lanes are read a clock after the synchronised enable, as the phy
	// drives them only in the cycles that follow its enable
	always_comb
	begin
		next_rx_byte = rx_byte;
		next_rx_valid = 1'b0;
		next_rx_start = 1'b0;
		next_rx_count = rx_count;
		next_rx_nibble = rx_nibble;
		next_rx_serial = rx_serial_bit;
		case (mode)
			fpm_mode_utopia:
			begin
				if (rx_take)
				begin
					next_rx_byte = rx_lvl;
					next_rx_valid = 1'b1;
					next_rx_start = (rx_count == 6'd0);
					if (rx_count == `FPM_CELL_LAST)
						next_rx_count = '0;
					else
						next_rx_count = rx_count + 6'd1;
				end
			end
			fpm_mode_nibble:
			begin
				// pin 7 carries the nibble lsb, pin 4 its msb
				next_rx_nibble = {rx_lvl[`FPM_NIB_RX_LO], rx_lvl[5],
					rx_lvl[6], rx_lvl[`FPM_PIN_17]};
				next_rx_count = '0;
			end
			fpm_mode_serial:
			begin
				next_rx_serial = rx_lvl[`FPM_SER_BIT];
				next_rx_count = '0;
			end
			default:
				next_rx_count = '0;
		endcase
	end

	// receive registers; the enable delays reset low, matching the idle
	// level of the pin, so no false pulse follows reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_en_d <= 1'b0;
			rx_en_dd <= 1'b0;
			rx_count <= '0;
			rx_byte <= '0;
			rx_byte_valid <= 1'b0;
			rx_cell_start <= 1'b0;
			rx_nibble <= '0;
			rx_serial_bit <= 1'b0;
		end
		else
		begin
			rx_en_d <= rx_en_lvl;
			rx_en_dd <= rx_en_d;
			rx_count <= next_rx_count;
			rx_byte <= next_rx_byte;
			rx_byte_valid <= next_rx_valid;
			rx_cell_start <= next_rx_start;
			rx_nibble <= next_rx_nibble;
			rx_serial_bit <= next_rx_serial;
		end
	end
endmodule // fpm_lane_map

// File: bench/fpm_lane_map_monitor.sv
// concurrent checks on the port a lane map pins
`timescale 1ns/10ps
module fpm_lane_map_monitor
	import fpm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire fpm_mode_type mode,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_ready,
	input wire logic tx_phy_enable,
	input wire logic dma_active,
	input wire logic [4:0] dma_sub_block,
	input wire logic dma_rx_section,
	input wire logic dma_error,
	input wire logic [7:0] pa_tx_out,
	input wire logic [7:0] pa_tx_oe,
	input wire logic [5:0] pa_id_out,
	input wire logic [5:0] pa_id_oe,
	input wire logic [5:0] dma_error_id,
	input wire logic dma_error_seen
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a byte is handed over on this edge
	sequence s_take;
		tx_byte_ready && tx_byte_valid;
	endsequence
	// error while the requester inputs sit still
	sequence s_err;
		dma_active && dma_error && $stable({dma_rx_section, dma_sub_block});
	endsequence
	utopia_oe_a: assert property (
		mode == fpm_mode_utopia |-> pa_tx_oe == 8'hFF)
		else $error("utopia lanes not driven");
	nibble_oe_a: assert property (
		mode == fpm_mode_nibble |-> pa_tx_oe == 8'hF0)
		else $error("nibble lanes wrong");
	serial_oe_a: assert property (
		mode == fpm_mode_serial |-> pa_tx_oe == 8'h80)
		else $error("serial lane wrong");
	id_oe_a: assert property (
		mode != fpm_mode_off |-> pa_id_oe == 6'h00)
		else $error("id pins driven");
	tx_byte_a: assert property (
		s_take |=> pa_tx_out == $past(tx_byte))
		else $error("taken byte not on lanes");
	ready_gate_a: assert property (
		tx_byte_ready |-> mode == fpm_mode_utopia && tx_phy_enable)
		else $error("ready outside utopia");
	id_value_a: assert property (
		dma_active |=> pa_id_out == {$past(dma_rx_section),
		$past(dma_sub_block)})
		else $error("requester id wrong");
	err_id_a: assert property (
		s_err |=> dma_error_seen &&
		dma_error_id == {$past(dma_rx_section), $past(dma_sub_block)})
		else $error("error id not captured");
	err_sticky_a: assert property (
		dma_error_seen |=> dma_error_seen)
		else $error("error flag dropped");
endmodule // fpm_lane_map_monitor

bind fpm_lane_map fpm_lane_map_monitor fpm_lane_map_monitor_inst (.clk, .rst,
	.mode, .tx_byte_valid, .tx_byte, .tx_byte_ready, .tx_phy_enable,
	.dma_active, .dma_sub_block, .dma_rx_section, .dma_error, .pa_tx_out,
	.pa_tx_oe, .pa_id_out, .pa_id_oe, .dma_error_id, .dma_error_seen);

// File: bench/fpm_phy_model.sv
// utopia phy model feeding two receive cells, the second one slowly
`timescale 1ns/10ps
module fpm_phy_model
(
	input wire logic clk,
	input wire logic go,
	output logic rx_phy_enable,
	output logic [7:0] pa_rx_in
);
	int c;
	int i;

	// one beat: enable for two clocks, lanes driven in the two clocks
	// that follow each enabled one, then released to the inverse; every
	// level stands two clocks so the block's pin filter passes it
	task automatic beat(input logic [7:0] d, input int gap);
		@(negedge clk);
		rx_phy_enable = 1'b1;
		@(negedge clk);
		pa_rx_in = d;
		@(negedge clk);
		rx_phy_enable = 1'b0;
		@(negedge clk);
		pa_rx_in = ~d;
		repeat (gap) @(negedge clk);
	endtask

	// released lanes show the inverse, never a stale byte
	initial
	begin
		rx_phy_enable = 1'b0;
		pa_rx_in = 8'hA5;
		@(posedge go);
		for (c = 0; c < 2; c++)
			for (i = 0; i < 53; i++)
				beat(8'h30 + 8'(i), c);
	end
endmodule // fpm_phy_model

// File: bench/fpm_lane_map_tb.sv
// self-checking bench for the port a lane map
`timescale 1ns/10ps
`include "fpm_params.svh"
module fpm_lane_map_tb;
	import fpm_pkg::*;
	logic clk, rst, go, tx_cell_start, tx_byte_valid, tx_byte_ready;
	logic tx_phy_enable, rx_phy_enable, tx_serial_bit, dma_active;
	logic dma_rx_section, dma_error, rx_byte_valid, rx_cell_start;
	logic rx_serial_bit, dma_error_seen;
	logic [7:0] tx_byte, pa_tx_out, pa_tx_oe, pa_rx_in, rx_byte, phy_rx;
	logic [7:0] pins, pend, b;
	logic [5:0] pa_id_out, pa_id_oe, dma_error_id;
	logic [4:0] dma_sub_block;
	logic [3:0] tx_nibble, rx_nibble;
	fpm_mode_type mode;
	int n_errors, cmp_count, rx_idx, i, k, seed;

	// phy owns the lanes only in utopia
	assign pa_rx_in = mode == fpm_mode_utopia ? phy_rx : pins;

	fpm_lane_map fpm_lane_map_inst (.clk, .rst, .mode, .tx_cell_start,
		.tx_byte_valid, .tx_byte, .tx_byte_ready, .tx_phy_enable,
		.rx_phy_enable, .tx_nibble, .tx_serial_bit, .dma_active,
		.dma_sub_block, .dma_rx_section, .dma_error, .pa_tx_out, .pa_tx_oe,
		.pa_rx_in, .pa_id_out, .pa_id_oe, .rx_byte, .rx_byte_valid,
		.rx_cell_start, .rx_nibble, .rx_serial_bit, .dma_error_id,
		.dma_error_seen);
	fpm_phy_model fpm_phy_model_inst (.clk, .go, .rx_phy_enable,
		.pa_rx_in(phy_rx));

	// 20 MHz clock
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	function automatic logic [3:0] rev4(input logic [3:0] x);
		return {x[0], x[1], x[2], x[3]};
	endfunction

	// idle cell: header, hec, then fill; underrun also gives fill
	function automatic logic [7:0] exp_tx(input int n, input logic v,
		input logic [7:0] d);
		if (v)
			return d;
		if (n % 53 < 4)
			return `FPM_IDLE_HDR;
		return n % 53 == 4 ? `FPM_IDLE_HEC : `FPM_IDLE_FILL;
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			n_errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic conclude;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// received bytes follow the phy count, start flag on byte 0
	always @(negedge clk)
		if (rx_byte_valid === 1'b1)
		begin
			chk(rx_byte, 8'h30 + 8'(rx_idx % 53));
			chk({7'h0, rx_cell_start}, {7'h0, rx_idx % 53 == 0});
			rx_idx++;
		end

	// hang guard
	initial
	begin
		#200000;
		n_errors++;
		conclude();
	end

	initial
	begin
		seed = 32'h4ab2acbb;
		{rst, go, tx_cell_start, tx_byte_valid, tx_phy_enable} = 5'h10;
		{tx_serial_bit, dma_active, dma_rx_section, dma_error} = 4'h0;
		mode = fpm_mode_utopia;
		{tx_byte, tx_nibble, pins, dma_sub_block, pend} = 0;
		{n_errors, cmp_count, rx_idx} = 0;
		repeat (2) @(negedge clk);
		rst = 0;
		go = 1;
		// user cell with stalls and an underrun at byte 10, then idle cell
		i = 0;
		while (i < 107)
		begin
			@(negedge clk);
			chk(pa_tx_out, pend);
			tx_phy_enable = i < 106 && ($random(seed) & 3) != 0;
			tx_byte_valid = i < 53 && i != 10;
			tx_cell_start = i == 0;
			tx_byte = 8'($random(seed));
			if (tx_phy_enable)
				pend = exp_tx(i, tx_byte_valid, tx_byte);
			if (tx_phy_enable || i == 106)
				i++;
		end
		for (k = 0; k < 1000 && rx_idx < 106; k++)
			@(negedge clk);
		chk(8'(rx_idx), 8'd106);
		// nibble and serial modes take turns
		tx_phy_enable = 1;
		for (i = 0; i < 32; i++)
		begin
			mode = i[0] ? fpm_mode_serial : fpm_mode_nibble;
			b = 8'($random(seed));
			tx_nibble = b[3:0];
			tx_serial_bit = b[1];
			pins = 8'($random(seed));
			repeat (8) @(negedge clk);
			if (i[0])
			begin
				chk(8'(pa_tx_out[7]), 8'(b[1]));
				chk(8'(rx_serial_bit), 8'(pins[7]));
			end
			else
			begin
				chk(8'(pa_tx_out[7:4]), 8'(rev4(b[3:0])));
				chk(8'(rx_nibble), 8'(rev4(pins[7:4])));
			end
		end
		// requester id and its capture on error
		mode = fpm_mode_off;
		dma_active = 1;
		for (i = 0; i < 8; i++)
		begin
			{dma_rx_section, dma_sub_block} = 6'($random(seed) ^ i);
			repeat (3) @(negedge clk);
			chk(8'(pa_id_out[4:0]), 8'(dma_sub_block));
			chk(8'(pa_id_out[5]), 8'(dma_rx_section));
			dma_error = 1;
			@(negedge clk);
			dma_error = 0;
			repeat (2) @(negedge clk);
			chk({1'b0, dma_error_seen, dma_error_id},
				{2'b01, dma_rx_section, dma_sub_block});
		end
		chk({pa_id_oe, 2'b0}, {pa_tx_oe[7:2], 2'b0} ^ 8'hFC);
		conclude();
	end
endmodule // fpm_lane_map_tb
